// >>> src/spfs_pkg.sv
// Shared constants for the shared pin function selector.
package spfs_pkg;
    // Pin and mode widths.
    localparam int NUM_PINS = 12;
    localparam int MODE_W = 3;
    localparam int SYNC_W = NUM_PINS + MODE_W;
    localparam int SYNC_STAGES = 2;
    localparam logic [1:0] CAPTURE_WAIT = 2'h2;

    // Index of each shared pin in the pin vectors.
    localparam int PIN_PORT3_BIT3 = 0;
    localparam int PIN_PORT3_BIT4 = 1;
    localparam int PIN_PORT3_BIT5 = 2;
    localparam int PIN_PORT3_BIT6 = 3;
    localparam int PIN_PORT3_BIT7 = 4;
    localparam int PIN_PORT4_BIT0 = 5;
    localparam int PIN_PORT4_BIT1 = 6;
    localparam int PIN_PORT4_BIT2 = 7;
    localparam int PIN_PORT4_BIT3 = 8;
    localparam int PIN_PORT9_BIT5 = 9;
    localparam int PIN_PORT9_BIT6 = 10;
    localparam int PIN_PORT9_BIT7 = 11;

    // Operating mode code that means single-chip operation.
    localparam logic [MODE_W-1:0] MODE_SINGLE_CHIP = 3'h3;
    localparam logic [MODE_W-1:0] MODE_RESET = 3'h3;

    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PORT_DATA = 8'h04;
    localparam logic [7:0] OFF_PORT_DIR = 8'h08;
    localparam logic [7:0] OFF_PIN_LEVEL = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;

    // Control register fields.
    localparam int CTRL_W = 7;
    localparam int CTRL_BUS16 = 0;
    localparam int CTRL_WRH_EN = 1;
    localparam int CTRL_HOLD_EN = 2;
    localparam int CTRL_READY_EN = 3;
    localparam int CTRL_CLKOUT_EN = 4;
    localparam int CTRL_CAN0_USE = 5;
    localparam int CTRL_CAN1_USE = 6;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

    // Port register reset values.
    localparam logic [NUM_PINS-1:0] PORT_DATA_RESET = 12'h000;
    localparam logic [NUM_PINS-1:0] PORT_DIR_RESET = 12'h000;

    // Status register fields.
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_EXT_BUS = 3;
    localparam int STAT_ALT_LSB = 4;
endpackage : spfs_pkg

// >>> src/spfs_sync_if.sv
// Carrier between the pin synchroniser and the selector top.
`timescale 1ns/1ps
`default_nettype none
interface spfs_sync_if #(
    parameter int W = 15
);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport driver (output raw, input synced);
    modport sync (input raw, output synced);
endinterface : spfs_sync_if
`default_nettype wire

// >>> src/spfs_sync.sv
// Two-flop synchroniser for pin levels entering the clock domain.
`timescale 1ns/1ps
`default_nettype none
module spfs_sync (
    input wire logic clock,
    input wire logic srst,
    spfs_sync_if.sync sif
);
    localparam int W = $bits(sif.raw);

    genvar i;
    // Each bit passes two flip-flops; the first is read only by the second.
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            logic meta_r;
            logic held_r;
            always_ff @(posedge clock) begin
                if (srst) begin
                    meta_r <= 1'b0;
                    held_r <= 1'b0;
                end else begin
                    meta_r <= sif.raw[i];
                    held_r <= meta_r;
                end
            end
            assign sif.synced[i] = held_r;
        end
    endgenerate
endmodule : spfs_sync
`default_nettype wire

// >>> src/spfs_top.sv
// Shared pin function selector with its register file on APB.
//
// Contract
// RULE1: High-byte write strobe only with external bus, 16-bit mode and strobe enabled.
// RULE2: Hold request input only when external bus and hold are enabled.
// RULE3: Hold acknowledge output only when external bus and hold are enabled.
// RULE4: Ready input only when external bus and external ready are enabled.
// RULE5: Clock output only when external bus and clock output are enabled.
// RULE6: Serial 0 transmit pin carries data while its output is enabled.
// RULE7: Serial 0 clock pin drives when enabled; level always usable as input.
// RULE8: Serial receive pins stay port bits and always feed the receivers.
// RULE9: CAN receive pins feed controllers; other drivers stop while CAN used.
// RULE10: CAN 1 transmit pin driven only when enabled and channel present.
// RULE11: Mode pins are tied to fixed levels and decoded for bus operation.
// RULE12: A selected alternate output overrides port data and direction.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module spfs_top #(
    parameter int CAN_CHANNELS = 2
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [spfs_pkg::NUM_PINS-1:0] pin_in,
    output logic [spfs_pkg::NUM_PINS-1:0] pin_out,
    output logic [spfs_pkg::NUM_PINS-1:0] pin_oe,
    input wire logic mode_select_bit0,
    input wire logic mode_select_bit1,
    input wire logic mode_select_bit2,
    input wire logic high_byte_write_strobe,
    input wire logic bus_hold_acknowledge,
    input wire logic bus_clock,
    input wire logic serial0_tx_data,
    input wire logic serial0_tx_enable,
    input wire logic serial0_clock_out,
    input wire logic serial0_clock_oe,
    input wire logic can1_transmit,
    input wire logic can1_tx_enable,
    output logic bus_hold_request,
    output logic bus_ready,
    output logic serial0_clock_in,
    output logic serial0_rx_data,
    output logic serial1_rx_data,
    output logic can0_receive,
    output logic can1_receive,
    output logic ext_bus_active
);
    localparam int N = spfs_pkg::NUM_PINS;
    localparam logic HAS_CAN1 = (CAN_CHANNELS > 1);

    // Decodes one register address; used for every register.
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr == off);
    endfunction : reg_hit

    logic [spfs_pkg::CTRL_W-1:0] ctrl_r;
    logic [N-1:0] port_data_r;
    logic [N-1:0] port_dir_r;
    logic [spfs_pkg::MODE_W-1:0] mode_r;
    logic mode_ok_r;
    logic [1:0] cap_cnt_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [N-1:0] pin_out_r;
    logic [N-1:0] pin_oe_r;
    logic hold_req_r;
    logic ready_r;
    logic sck_in_r;
    logic rx0_r;
    logic rx1_r;
    logic can0_rx_r;
    logic can1_rx_r;
    logic ext_bus_r;

    // Pin and mode levels pass the synchroniser before any logic reads them.
    spfs_sync_if #(.W(spfs_pkg::SYNC_W)) sif ();
    assign sif.raw = {mode_select_bit2, mode_select_bit1, mode_select_bit0, pin_in};
    spfs_sync u_sync (
        .clock(clock),
        .srst(srst),
        .sif(sif.sync)
    );

    logic [N-1:0] pin_lvl;
    logic [spfs_pkg::MODE_W-1:0] mode_lvl;
    assign pin_lvl = sif.synced[N-1:0];
    assign mode_lvl = sif.synced[spfs_pkg::SYNC_W-1:N];

    // Mode decode: single-chip until the strap is caught after reset.
    logic ext_bus;
    assign ext_bus = mode_ok_r && (mode_r != spfs_pkg::MODE_SINGLE_CHIP);

    // RULE11: strap capture
    // The mode straps are static, so they are caught once the synchroniser has filled.
    always_ff @(posedge clock) begin
        if (srst) begin
            mode_r <= spfs_pkg::MODE_RESET;
            mode_ok_r <= 1'b0;
            cap_cnt_r <= 2'h0;
        end else if (!mode_ok_r) begin
            if (cap_cnt_r == spfs_pkg::CAPTURE_WAIT) begin
                mode_r <= mode_lvl;
                mode_ok_r <= 1'b1;
            end else begin
                cap_cnt_r <= cap_cnt_r + 2'h1;
            end
        end
    end

    // Function enables taken from the control register.
    logic bus16;
    logic wrh_en;
    logic hold_en;
    logic ready_en;
    logic clkout_en;
    logic can0_use;
    logic can1_use;
    assign bus16 = ctrl_r[spfs_pkg::CTRL_BUS16];
    assign wrh_en = ctrl_r[spfs_pkg::CTRL_WRH_EN];
    assign hold_en = ctrl_r[spfs_pkg::CTRL_HOLD_EN];
    assign ready_en = ctrl_r[spfs_pkg::CTRL_READY_EN];
    assign clkout_en = ctrl_r[spfs_pkg::CTRL_CLKOUT_EN];
    assign can0_use = ctrl_r[spfs_pkg::CTRL_CAN0_USE];
    assign can1_use = ctrl_r[spfs_pkg::CTRL_CAN1_USE] && HAS_CAN1;

    // Per-function selection terms.
    logic wrh_sel;
    logic hrq_sel;
    logic hak_sel;
    logic rdy_sel;
    logic clk_sel;
    logic can1_tx_sel;
    // RULE1: strobe select
    assign wrh_sel = ext_bus && bus16 && wrh_en;
    // RULE2: hold request select
    assign hrq_sel = ext_bus && hold_en;
    // RULE3: hold acknowledge select
    assign hak_sel = ext_bus && hold_en;
    // RULE4: ready select
    assign rdy_sel = ext_bus && ready_en;
    // RULE5: clock output select
    assign clk_sel = ext_bus && clkout_en;
    // RULE10: transmit select
    assign can1_tx_sel = can1_tx_enable && HAS_CAN1;

    // Alternate output selects and values, one bit per shared pin.
    logic [N-1:0] alt_out_sel;
    logic [N-1:0] alt_out_val;
    logic [N-1:0] alt_in_sel;
    // RULE6: serial data select
    // RULE7: serial clock select
    assign alt_out_sel = {1'b0, can1_tx_sel, 1'b0, 1'b0, 1'b0, serial0_clock_oe,
                          serial0_tx_enable, clk_sel, 1'b0, hak_sel, 1'b0, wrh_sel};
    assign alt_out_val = {1'b0, can1_transmit, 1'b0, 1'b0, 1'b0, serial0_clock_out,
                          serial0_tx_data, bus_clock, 1'b0, bus_hold_acknowledge, 1'b0,
                          high_byte_write_strobe};
    // RULE9: drive stop
    // Input functions keep the pin from being driven while they own it.
    assign alt_in_sel = {can1_use, 1'b0, can0_use, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                         rdy_sel, 1'b0, hrq_sel, 1'b0};

    // Next pin drive for every shared pin.
    logic [N-1:0] pin_out_nxt;
    logic [N-1:0] pin_oe_nxt;
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_pin
            // RULE12: alternate override
            assign pin_out_nxt[g] = alt_out_sel[g] ? alt_out_val[g] : port_data_r[g];
            assign pin_oe_nxt[g] = alt_out_sel[g] | (~alt_in_sel[g] & port_dir_r[g]);
        end
    endgenerate

    // Registered pin drive.
    always_ff @(posedge clock) begin
        if (srst) begin
            pin_out_r <= spfs_pkg::PORT_DATA_RESET;
            pin_oe_r <= spfs_pkg::PORT_DIR_RESET;
        end else begin
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
        end
    end

    // Levels handed to the peripherals; hold request and ready sit at idle while unselected.
    always_ff @(posedge clock) begin
        if (srst) begin
            hold_req_r <= 1'b0;
            ready_r <= 1'b1;
            sck_in_r <= 1'b0;
            rx0_r <= 1'b1;
            rx1_r <= 1'b1;
            can0_rx_r <= 1'b1;
            can1_rx_r <= 1'b1;
            ext_bus_r <= 1'b0;
        end else begin
            // RULE2: hold request routing
            hold_req_r <= hrq_sel & pin_lvl[spfs_pkg::PIN_PORT3_BIT4];
            // RULE4: ready routing
            ready_r <= rdy_sel ? pin_lvl[spfs_pkg::PIN_PORT3_BIT6] : 1'b1;
            // RULE7: clock input level
            sck_in_r <= pin_lvl[spfs_pkg::PIN_PORT4_BIT1];
            // RULE8: receiver feed
            rx0_r <= pin_lvl[spfs_pkg::PIN_PORT4_BIT2];
            rx1_r <= pin_lvl[spfs_pkg::PIN_PORT4_BIT3];
            // RULE9: CAN receive feed
            can0_rx_r <= pin_lvl[spfs_pkg::PIN_PORT9_BIT5];
            can1_rx_r <= HAS_CAN1 ? pin_lvl[spfs_pkg::PIN_PORT9_BIT7] : 1'b1;
            ext_bus_r <= ext_bus;
        end
    end

    // APB decode: setup phase prepares the answer, access phase completes it.
    logic setup_ph;
    logic wr_go;
    logic hit_ctrl;
    logic hit_data;
    logic hit_dir;
    logic hit_lvl;
    logic hit_stat;
    logic hit_any;
    logic [31:0] rd_word;
    logic [31:0] status_word;
    assign setup_ph = psel && !penable;
    assign wr_go = psel && penable && pready_r && pwrite;
    assign hit_ctrl = reg_hit(paddr, spfs_pkg::OFF_CTRL);
    assign hit_data = reg_hit(paddr, spfs_pkg::OFF_PORT_DATA);
    assign hit_dir = reg_hit(paddr, spfs_pkg::OFF_PORT_DIR);
    assign hit_lvl = reg_hit(paddr, spfs_pkg::OFF_PIN_LEVEL);
    assign hit_stat = reg_hit(paddr, spfs_pkg::OFF_STATUS);
    assign hit_any = hit_ctrl | hit_data | hit_dir | hit_lvl | hit_stat;
    assign status_word = {16'h0000, alt_out_sel | alt_in_sel, ext_bus, mode_r};
    assign rd_word = hit_ctrl ? {25'h0000000, ctrl_r} :
                     hit_data ? {20'h00000, port_data_r} :
                     hit_dir ? {20'h00000, port_dir_r} :
                     hit_lvl ? {20'h00000, pin_lvl} :
                     hit_stat ? status_word : 32'h00000000;

    // Bus answer registers: one wait-free access cycle after each setup.
    always_ff @(posedge clock) begin
        if (srst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= setup_ph;
            pslverr_r <= setup_ph && !hit_any;
            prdata_r <= (setup_ph && !pwrite) ? rd_word : 32'h00000000;
        end
    end

    // Register writes take effect at the completing access edge.
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_r <= spfs_pkg::CTRL_RESET;
            port_data_r <= spfs_pkg::PORT_DATA_RESET;
            port_dir_r <= spfs_pkg::PORT_DIR_RESET;
        end else if (wr_go) begin
            if (hit_ctrl) begin
                ctrl_r <= pwdata[spfs_pkg::CTRL_W-1:0];
            end
            if (hit_data) begin
                port_data_r <= pwdata[N-1:0];
            end
            if (hit_dir) begin
                port_dir_r <= pwdata[N-1:0];
            end
        end
    end

    // Outputs come straight from their flip-flops.
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;
    assign bus_hold_request = hold_req_r;
    assign bus_ready = ready_r;
    assign serial0_clock_in = sck_in_r;
    assign serial0_rx_data = rx0_r;
    assign serial1_rx_data = rx1_r;
    assign can0_receive = can0_rx_r;
    assign can1_receive = can1_rx_r;
    assign ext_bus_active = ext_bus_r;

    // Checks on pin selection and the bus answer.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    property p_wrh;
        wrh_sel |=> pin_oe[spfs_pkg::PIN_PORT3_BIT3]
            && (pin_out[spfs_pkg::PIN_PORT3_BIT3] == $past(high_byte_write_strobe));
    endproperty
    a_wrh: assert property (p_wrh) // RULE1
        else $error("strobe pin not driven by strobe");

    property p_wrh_off;
        (!ext_bus || !bus16) |=> (pin_oe[spfs_pkg::PIN_PORT3_BIT3] == $past(port_dir_r[0]));
    endproperty
    a_wrh_off: assert property (p_wrh_off) // RULE1
        else $error("strobe pin left port function");

    property p_hrq;
        hrq_sel ##1 hrq_sel |=> !pin_oe[spfs_pkg::PIN_PORT3_BIT4]
            && (bus_hold_request == $past(pin_lvl[spfs_pkg::PIN_PORT3_BIT4]));
    endproperty
    a_hrq: assert property (p_hrq) // RULE2
        else $error("hold request not routed");

    property p_hak;
        hak_sel |=> pin_oe[spfs_pkg::PIN_PORT3_BIT5]
            && (pin_out[spfs_pkg::PIN_PORT3_BIT5] == $past(bus_hold_acknowledge));
    endproperty
    a_hak: assert property (p_hak) // RULE3
        else $error("hold acknowledge not driven");

    property p_rdy;
        !rdy_sel |=> bus_ready;
    endproperty
    a_rdy: assert property (p_rdy) // RULE4
        else $error("ready not idle while unselected");

    property p_clk;
        clk_sel |=> pin_oe[spfs_pkg::PIN_PORT3_BIT7]
            && (pin_out[spfs_pkg::PIN_PORT3_BIT7] == $past(bus_clock));
    endproperty
    a_clk: assert property (p_clk) // RULE5
        else $error("clock output not driven");

    property p_serial0_tx_data;
        serial0_tx_enable |=> pin_oe[spfs_pkg::PIN_PORT4_BIT0]
            && (pin_out[spfs_pkg::PIN_PORT4_BIT0] == $past(serial0_tx_data));
    endproperty
    a_serial0_tx_data: assert property (p_serial0_tx_data) // RULE6
        else $error("serial data pin not driven");

    property p_serial0_clock_pin;
        !srst |=> serial0_clock_in == $past(pin_lvl[spfs_pkg::PIN_PORT4_BIT1]);
    endproperty
    a_serial0_clock_pin: assert property (p_serial0_clock_pin) // RULE7
        else $error("serial clock level not passed");

    property p_rx;
        !srst |=> (serial0_rx_data == $past(pin_lvl[spfs_pkg::PIN_PORT4_BIT2]))
            && (pin_oe[spfs_pkg::PIN_PORT4_BIT2] == $past(port_dir_r[7]));
    endproperty
    a_rx: assert property (p_rx) // RULE8
        else $error("receive pin lost port function");

    property p_can_rx;
        can0_use |=> !pin_oe[spfs_pkg::PIN_PORT9_BIT5];
    endproperty
    a_can_rx: assert property (p_can_rx) // RULE9
        else $error("CAN receive pin still driven");

    property p_can1_tx;
        !can1_tx_sel |=> (pin_oe[spfs_pkg::PIN_PORT9_BIT6] == $past(port_dir_r[10]))
            && (pin_out[spfs_pkg::PIN_PORT9_BIT6] == $past(port_data_r[10]));
    endproperty
    a_can1_tx: assert property (p_can1_tx) // RULE10
        else $error("CAN transmit pin left port function");

    property p_override;
        (!alt_out_sel[5] && !alt_in_sel[5]) ##1 !alt_out_sel[5]
            |-> (pin_out[5] == $past(port_data_r[5]));
    endproperty
    a_override: assert property (p_override) // RULE12
        else $error("port data not restored");

    property p_apb;
        setup_ph |=> pready ##1 !pready;
    endproperty
    a_apb: assert property (p_apb)
        else $error("bus answer not one access cycle");
endmodule : spfs_top
`default_nettype wire

// >>> verif/spfs_pin_partner.sv
// Behavioural model of the bus devices and transceivers wired to the shared pads.
`timescale 1ns/1ps
`default_nettype none
module spfs_pin_partner (
    input wire logic clock,
    input wire logic [spfs_pkg::NUM_PINS-1:0] pin_out,
    input wire logic [spfs_pkg::NUM_PINS-1:0] pin_oe,
    input wire logic [spfs_pkg::NUM_PINS-1:0] ext_en,
    input wire logic [spfs_pkg::NUM_PINS-1:0] ext_val,
    output logic [spfs_pkg::NUM_PINS-1:0] pin_in
);
    logic [spfs_pkg::NUM_PINS-1:0] float_r = 12'hA5A;
    // An undriven pad wanders every cycle, so a stale level is never taken as valid.
    always @(posedge clock) begin
        float_r <= ~float_r;
    end
    // far drive on request
    // The block wins where it drives; the far device drives only where asked.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & float_r);
endmodule : spfs_pin_partner
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking testbench for the shared pin function selector.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock, srst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [11:0] pin_in, pin_out, pin_oe, ext_en, ext_val;
    logic [2:0] mode;
    logic [8:0] per;
    logic bhr, brdy, s0ci, s0rx, s1rx, c0rx, c1rx, ext_act;
    int fail_count, comparisons;
    logic [6:0] ct [4] = '{7'h7F, 7'h02, 7'h1D, 7'h00};
    logic [11:0] dr [4] = '{12'hFFF, 12'hFFF, 12'h000, 12'hFFF};
    logic [11:0] dt [4] = '{12'h0F0, 12'hF0F, 12'hFFF, 12'h555};
    logic [8:0] pt [4] = '{9'h1FF, 9'h155, 9'h0AA, 9'h100};
    logic [11:0] ev [4] = '{12'h5A5, 12'hA5A, 12'hFFF, 12'h000};

    spfs_top spfs_top_inst (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .mode_select_bit0(mode[0]), .mode_select_bit1(mode[1]), .mode_select_bit2(mode[2]),
        .high_byte_write_strobe(per[0]), .bus_hold_acknowledge(per[1]), .bus_clock(per[2]),
        .serial0_tx_data(per[3]), .serial0_tx_enable(per[4]), .serial0_clock_out(per[5]),
        .serial0_clock_oe(per[6]), .can1_transmit(per[7]), .can1_tx_enable(per[8]),
        .bus_hold_request(bhr), .bus_ready(brdy), .serial0_clock_in(s0ci),
        .serial0_rx_data(s0rx), .serial1_rx_data(s1rx), .can0_receive(c0rx),
        .can1_receive(c1rx), .ext_bus_active(ext_act));

    spfs_pin_partner spfs_pin_partner_inst (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    // The clock runs at 40 MHz.
    initial begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end

    // Counts a comparison and reports a mismatch at once.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    // One APB transfer: setup, then access held until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge clock);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        // Only the watchdog ends a wait that never sees pready.
        do begin
            @(posedge clock);
        end while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // Register read compared with its expected word and error flag.
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'h0, a, 32'h0, r, e);
        check(r, x);
        check({31'h0, e}, {31'h0, xe});
    endtask : rd

    // Register write with its error flag compared.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'h1, a, d, r, e);
        check({31'h0, e}, {31'h0, xe});
    endtask : wr

    // straps held fixed
    // Straps change only under reset and then stay put while the block runs.
    task automatic do_reset(input logic [2:0] m);
        @(posedge clock);
        srst <= 1'h1;
        mode <= m;
        repeat (10) @(posedge clock);
        srst <= 1'h0;
        repeat (6) @(posedge clock);
    endtask : do_reset

    // Expected pad enables and levels, packed as {oe, out}.
    function automatic logic [23:0] exp_pins(input logic x, input logic [6:0] c,
        input logic [11:0] dir, input logic [11:0] dat, input logic [8:0] p);
        logic [11:0] oe;
        logic [11:0] o;
        oe = dir;
        o = dat;
        if (x && c[0] && c[1]) begin
            oe[0] = 1'h1;
            o[0] = p[0];
        end
        if (x && c[2]) begin
            oe[1] = 1'h0;
            oe[2] = 1'h1;
            o[2] = p[1];
        end
        if (x && c[3]) oe[3] = 1'h0;
        if (x && c[4]) begin
            oe[4] = 1'h1;
            o[4] = p[2];
        end
        if (p[4]) begin
            oe[5] = 1'h1;
            o[5] = p[3];
        end
        if (p[6]) begin
            oe[6] = 1'h1;
            o[6] = p[5];
        end
        if (c[5]) oe[9] = 1'h0;
        if (c[6]) oe[11] = 1'h0;
        if (p[8]) begin
            oe[10] = 1'h1;
            o[10] = p[7];
        end
        return {oe, o};
    endfunction : exp_pins

    // Applies one setting and compares pad drive, receiver feeds and pad levels.
    task automatic pins(input logic x, input int i);
        logic [23:0] e;
        logic [11:0] lv;
        e = exp_pins(x, ct[i], dr[i], dt[i], pt[i]);
        lv = (e[23:12] & e[11:0]) | (~e[23:12] & ev[i]);
        wr(8'h00, {25'h0, ct[i]}, 1'h0);
        wr(8'h04, {20'h0, dt[i]}, 1'h0);
        wr(8'h08, {20'h0, dr[i]}, 1'h0);
        per <= pt[i];
        ext_val <= ev[i];
        repeat (5) @(posedge clock);
        check({20'h0, pin_oe}, {20'h0, e[23:12]});
        check({20'h0, pin_out & e[23:12]}, {20'h0, e[11:0] & e[23:12]});
        check({25'h0, bhr, brdy, s0ci, s0rx, s1rx, c0rx, c1rx}, {25'h0, x & ct[i][2] & lv[1],
            ~(x & ct[i][3]) | lv[3], lv[6], lv[7], lv[8], lv[9], lv[11]});
        check({31'h0, ext_act}, {31'h0, x});
        rd(8'h0C, {20'h0, lv}, 1'h0);
    endtask : pins

    // Cuts a hung run short.
    initial begin
        repeat (5000) @(posedge clock);
        fail_count++;
        end_sim();
    end

    // Main sequence: registers, then pin selection in both strap modes.
    initial begin
        logic [31:0] r;
        logic e;
        srst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mode = 3'h3;
        per = 9'h000;
        ext_en = 12'hFFF;
        ext_val = 12'h000;
        fail_count = 0;
        comparisons = 0;
        do_reset(spfs_pkg::MODE_SINGLE_CHIP);
        rd(8'h00, 32'h0, 1'h0);
        rd(8'h04, 32'h0, 1'h0);
        rd(8'h08, 32'h0, 1'h0);
        wr(8'h04, 32'hFFFFFFFF, 1'h0);
        rd(8'h04, 32'h00000FFF, 1'h0);
        wr(8'h0C, 32'hFFFFFFFF, 1'h0);
        wr(8'h14, 32'hFFFFFFFF, 1'h1);
        rd(8'h14, 32'h0, 1'h1);
        rd(8'h02, 32'h0, 1'h1);
        apb(1'h0, 8'h10, 32'h0, r, e);
        check({28'h0, r[3:0]}, {28'h0, 1'h0, spfs_pkg::MODE_SINGLE_CHIP});
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            pins(1'h0, i);
        end
        $display("test single chip done");
        do_reset(3'h0);
        for (int i = 0; i < 4; i++) begin
            pins(1'h1, i);
        end
        rd(8'h10, 32'h00004008, 1'h0);
        $display("test external bus done");
        end_sim();
    end
endmodule : testbench
`default_nettype wire
